// File: rtl/phy_link_iface_reset_disable_init.sv
// link interface reset, disable and initialisation sequencer
`timescale 1ns/1ps

module phy_link_iface_reset_disable_init
    import link_iface_pkg::*;
#(
    parameter int unsigned WAKE_CYCLES = WAKE_CYC
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // pins from the link layer controller and the board
    input wire logic link_power_status,
    input wire logic isolated_mode_n,
    input wire logic ports_active,
    input wire logic link_request_line,
    // same-domain request and status handshakes
    input wire logic request_served,
    input wire logic status_event,
    input wire logic status_taken,
    // link-side clock pin
    output logic link_side_clock,
    output logic link_side_clock_oe,
    // control and data lines, one enable for both
    output logic [CTL_W-1:0] control_lines,
    output logic [DATA_W-1:0] data_lines,
    output logic link_lines_oe,
    // state reporting
    output logic low_power,
    output logic interface_ready,
    output logic request_pending,
    output logic status_pending
);

    localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(WAKE_CYCLES - 1);

    // reset-style lines: floated in isolated mode, driven low otherwise
    function automatic logic rest_drive(input logic iso);
        rest_drive = !iso;
    endfunction : rest_drive

    logic [PIN_N-1:0] pin_meta;
    logic [PIN_N-1:0] pin_sync;
    logic power_ok;
    logic isolated;
    logic ports_on;
    logic req_seen;

    iface_state_t state;
    iface_state_t next_state;
    logic [WAKE_W-1:0] wake_cnt;
    logic [WAKE_W-1:0] next_wake_cnt;
    logic [CYC_W-1:0] cycle_cnt;
    logic [CYC_W-1:0] next_cycle_cnt;
    logic clk_run;
    logic next_clk_run;
    logic [CTL_W-1:0] next_ctl;
    logic [DATA_W-1:0] next_data;
    logic next_oe;
    logic next_low_power;
    logic next_ready;
    logic next_req_pending;
    logic next_status_pending;
    logic reset_hit;
    logic disable_hit;
    logic link_rise;
    logic oper_stays;

    // every pin passes two flops before use
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
        end
        else
        begin
            pin_meta <= {link_request_line, ports_active, isolated_mode_n, link_power_status};
            pin_sync <= pin_meta;
        end
    end

    assign power_ok = pin_sync[PIN_POWER];
    assign isolated = !pin_sync[PIN_ISO_N];
    assign ports_on = pin_sync[PIN_PORTS];
    assign req_seen = pin_sync[PIN_REQ];

    power_status_timer u_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .power_ok(power_ok),
        .reset_hit(reset_hit),
        .disable_hit(disable_hit)
    );

    link_clock_gen u_clk (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(clk_run),
        .isolated(isolated),
        .link_clk(link_side_clock),
        .link_clk_oe(link_side_clock_oe),
        .rise(link_rise)
    );

    // sequence state
    always_comb
    begin
        next_state = state;
        next_wake_cnt = wake_cnt;
        next_cycle_cnt = cycle_cnt;
        case (state)
            ST_DISABLED:
                if (power_ok)
                begin
                    if (low_power)
                    begin
                        next_state = ST_WAKE;
                        next_wake_cnt = '0;
                    end
                    else
                    begin
                        next_state = ST_INIT;
                        next_cycle_cnt = '0;
                    end
                end
            ST_WAKE:
                if (wake_cnt == WAKE_LAST)
                begin
                    next_state = ST_INIT;
                    next_cycle_cnt = '0;
                end
                else
                    next_wake_cnt = wake_cnt + 1'b1;
            ST_RESET:
                if (power_ok)
                begin
                    next_state = ST_INIT;
                    next_cycle_cnt = '0;
                end
            ST_INIT:
                if (link_rise)
                begin
                    next_cycle_cnt = cycle_cnt + 1'b1;
                    if (cycle_cnt + 1'b1 == RECEIVE_CYCLE)
                        next_state = ST_RECEIVE;
                end
            ST_RECEIVE:
                if (link_rise)
                    next_state = ST_OPER;
            ST_OPER:
                next_state = ST_OPER;
            default:
                next_state = ST_DISABLED;
        endcase
        // the detections lag power status by a cycle, so gate them with it
        if (!power_ok && disable_hit && state != ST_DISABLED)
            next_state = ST_DISABLED;
        else if (!power_ok && reset_hit &&
                 (state == ST_INIT || state == ST_RECEIVE || state == ST_OPER))
            next_state = ST_RESET;
    end

    // line drive and reporting, registered from the next state
    always_comb
    begin
        next_ctl = CTL_IDLE;
        next_data = DATA_ZERO;
        next_oe = rest_drive(isolated);
        case (next_state)
            ST_INIT:
                if (next_cycle_cnt == FIRST_CYCLE)
                    next_oe = 1'b1;
                else
                    next_oe = rest_drive(isolated);
            ST_RECEIVE:
            begin
                next_ctl = CTL_RECEIVE;
                next_data = DATA_ONES;
                next_oe = 1'b1;
            end
            ST_OPER:
                next_oe = 1'b1;
            default:
                next_oe = rest_drive(isolated);
        endcase
        next_clk_run = (next_state == ST_RESET) || (next_state == ST_INIT) ||
                       (next_state == ST_RECEIVE) || (next_state == ST_OPER);
        next_low_power = (next_state == ST_DISABLED) && !ports_on;
        next_ready = (next_state == ST_OPER);
        oper_stays = (state == ST_OPER) && (next_state == ST_OPER);
        // a new event wins over a clear in the same cycle
        next_req_pending = oper_stays &&
                           (req_seen || (request_pending && !request_served));
        next_status_pending = oper_stays &&
                              (status_event || (status_pending && !status_taken));
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state <= ST_DISABLED;
            wake_cnt <= '0;
            cycle_cnt <= '0;
            clk_run <= 1'b0;
            control_lines <= CTL_IDLE;
            data_lines <= DATA_ZERO;
            link_lines_oe <= 1'b0;
            low_power <= 1'b0;
            interface_ready <= 1'b0;
            request_pending <= 1'b0;
            status_pending <= 1'b0;
        end
        else
        begin
            state <= next_state;
            wake_cnt <= next_wake_cnt;
            cycle_cnt <= next_cycle_cnt;
            clk_run <= next_clk_run;
            control_lines <= next_ctl;
            data_lines <= next_data;
            link_lines_oe <= next_oe;
            low_power <= next_low_power;
            interface_ready <= next_ready;
            request_pending <= next_req_pending;
            status_pending <= next_status_pending;
        end
    end

    hw_reset_disabled_a: assert property (@(posedge clk_sys)
        !rst_n |=> state == ST_DISABLED && !clk_run)
        else $error("hardware reset does not leave the interface disabled");

    disable_entry_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!power_ok && disable_hit && state == ST_RESET)
        |=> state == ST_DISABLED ##2 !link_side_clock)
        else $error("long deassertion does not disable the interface");

    reset_entry_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!power_ok && reset_hit && !disable_hit && state == ST_OPER)
        |=> state == ST_RESET && data_lines == DATA_ZERO && control_lines == CTL_IDLE
            && link_lines_oe == !isolated)
        else $error("reset detection does not park the lines");

    clock_pin_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state == ST_DISABLED && $past(state) == ST_DISABLED && $stable(isolated))
        |-> !link_side_clock && link_side_clock_oe == !isolated)
        else $error("stopped link-side clock pin in the wrong state");

    low_power_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state == ST_DISABLED && next_state == ST_DISABLED && !ports_on) |=> low_power)
        else $error("disabled with idle ports but not in low power");

    fast_restart_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state == ST_DISABLED && power_ok && !low_power)
        |=> state == ST_INIT && clk_run ##2 link_side_clock)
        else $error("link-side clock not restarted promptly");

    wake_restart_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state == ST_WAKE && wake_cnt == WAKE_LAST && power_ok) |=> state == ST_INIT)
        else $error("wake wait does not end at the wake count");

    iso_one_cycle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state == ST_INIT && isolated && $stable(isolated) && cycle_cnt != FIRST_CYCLE)
        |-> !link_lines_oe)
        else $error("isolated lines driven outside the first full cycle");

    direct_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state == ST_INIT && !isolated && $stable(isolated) && cycle_cnt <= LAST_LOW_CYCLE)
        |-> link_lines_oe && data_lines == DATA_ZERO && control_lines == CTL_IDLE)
        else $error("direct mode lines not held low during first seven cycles");

    receive_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state == ST_INIT && link_rise && cycle_cnt == LAST_LOW_CYCLE && power_ok)
        |=> control_lines == CTL_RECEIVE && data_lines == DATA_ONES && link_lines_oe)
        else $error("receive indication missing on the eighth cycle");

    ready_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (request_pending || status_pending) |-> interface_ready && state == ST_OPER)
        else $error("request or status kept while not operational");

    idle_after_receive_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state == ST_RECEIVE && link_rise && power_ok)
        |=> interface_ready && control_lines == CTL_IDLE && data_lines == DATA_ZERO)
        else $error("idle not shown after receive indication");

    reset_seen_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        state == ST_OPER ##1 state == ST_RESET);

    reinit_from_reset_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        state == ST_RESET ##1 state == ST_INIT);

    wake_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        state == ST_WAKE ##1 state == ST_INIT);

    operational_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        state == ST_RECEIVE ##1 state == ST_OPER);

endmodule : phy_link_iface_reset_disable_init

// File: rtl/link_iface_pkg.sv
// constants and types for the link interface reset, disable and init sequencer
package link_iface_pkg;

    // local clock
    localparam int unsigned CLK_PERIOD_NS = 25;

    // power-status deassertion timing, least times round up to whole cycles
    localparam int unsigned T_RESET_MIN_NS = 2600;
    localparam int unsigned T_DISABLE_MIN_NS = 26030;
    localparam int unsigned RESET_CYC = (T_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DISABLE_CYC =
        (T_DISABLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // wake from low power before the link-side clock restarts
    localparam int unsigned T_WAKE_MIN_NS = 5300000;
    localparam int unsigned WAKE_CYC = (T_WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // counter widths
    localparam int DLY_W = 11;
    localparam int WAKE_W = 19;
    localparam int CYC_W = 4;
    localparam logic [DLY_W-1:0] RESET_CNT = DLY_W'(RESET_CYC);
    localparam logic [DLY_W-1:0] DISABLE_CNT = DLY_W'(DISABLE_CYC);

    // link-side clock cycles counted from power-status reassertion
    localparam logic [CYC_W-1:0] FIRST_CYCLE = 4'h1;
    localparam logic [CYC_W-1:0] LAST_LOW_CYCLE = 4'h7;
    localparam logic [CYC_W-1:0] RECEIVE_CYCLE = 4'h8;

    // line widths and codes
    localparam int CTL_W = 2;
    localparam int DATA_W = 8;
    localparam logic [CTL_W-1:0] CTL_IDLE = 2'h0;
    localparam logic [CTL_W-1:0] CTL_RECEIVE = 2'h2;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] DATA_ONES = 8'hff;

    // pin synchroniser slots
    localparam int PIN_N = 4;
    localparam int PIN_POWER = 0;
    localparam int PIN_ISO_N = 1;
    localparam int PIN_PORTS = 2;
    localparam int PIN_REQ = 3;

    typedef enum logic [2:0] {
        ST_DISABLED = 3'b000,
        ST_WAKE = 3'b001,
        ST_RESET = 3'b010,
        ST_INIT = 3'b011,
        ST_RECEIVE = 3'b100,
        ST_OPER = 3'b101
    } iface_state_t;

endpackage : link_iface_pkg

// File: rtl/power_status_timer.sv
// deassertion timer for the power-status line on the local clock
`timescale 1ns/1ps
module power_status_timer
    import link_iface_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // synchronised power status
    input wire logic power_ok,
    // detections
    output logic reset_hit,
    output logic disable_hit
);

    logic [DLY_W-1:0] cnt;
    logic [DLY_W-1:0] next_cnt;
    logic next_reset_hit;
    logic next_disable_hit;

    // saturates so a long disable never wraps back into a reset detection
    always_comb
    begin
        if (power_ok)
            next_cnt = '0;
        else if (cnt == DISABLE_CNT)
            next_cnt = cnt;
        else
            next_cnt = cnt + 1'b1;
        next_reset_hit = !power_ok && (next_cnt >= RESET_CNT);
        next_disable_hit = !power_ok && (next_cnt == DISABLE_CNT);
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            cnt <= '0;
            reset_hit <= 1'b0;
            disable_hit <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            reset_hit <= next_reset_hit;
            disable_hit <= next_disable_hit;
        end
    end

    count_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        power_ok |=> (cnt == '0) && !reset_hit && !disable_hit)
        else $error("deassert count not cleared by asserted power status");

    reset_time_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!power_ok && cnt == RESET_CNT - 1'b1) |=> reset_hit && !$past(reset_hit))
        else $error("reset detection not at the reset-detect count");

    disable_time_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(disable_hit) |-> cnt == DISABLE_CNT && $past(cnt) == DISABLE_CNT - 1'b1)
        else $error("disable detection not at the disable-detect count");

endmodule : power_status_timer

// File: rtl/link_clock_gen.sv
// link-side clock divider with half-cycle low start
`timescale 1ns/1ps
module link_clock_gen
    import link_iface_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // control
    input wire logic run,
    input wire logic isolated,
    // clock pin and edge marker
    output logic link_clk,
    output logic link_clk_oe,
    output logic rise
);

    logic started;
    logic next_clk;
    logic next_oe;
    logic next_rise;

    // divide by two; the first half cycle after start stays low
    always_comb
    begin
        next_clk = run && started && !link_clk;
        next_oe = run || !isolated;
        next_rise = next_clk && !link_clk;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            started <= 1'b0;
            link_clk <= 1'b0;
            link_clk_oe <= 1'b0;
            rise <= 1'b0;
        end
        else
        begin
            started <= run;
            link_clk <= next_clk;
            link_clk_oe <= next_oe;
            rise <= next_rise;
        end
    end

    clk_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !run |=> !link_clk [*2])
        else $error("link-side clock toggles while stopped");

    start_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ($rose(run) ##1 run) |-> !link_clk ##1 link_clk)
        else $error("link-side clock does not start with a low half cycle");

endmodule : link_clock_gen

// File: tb/link_ctrl_model.sv
// controller-side model driving the power-status and request pins
`timescale 1ns/1ps
module link_ctrl_model
#(
    parameter int RESTORE_CYC = 600
)
(
    // clock
    input wire logic clk_sys,
    // commands from the bench
    input wire logic want_power,
    input wire logic want_req,
    // pins toward the device
    output logic link_power_status,
    output logic link_request_line
);
    int low_cnt;

    initial
    begin
        low_cnt = 0;
        link_power_status = 1'b0;
        link_request_line = 1'b0;
    end

    always @(posedge clk_sys)
    begin
        low_cnt <= link_power_status ? 0 : (low_cnt < RESTORE_CYC ? low_cnt + 1 : low_cnt);
        // no reassertion before the isolation circuits had time to settle
        link_power_status <= want_power &
                             (link_power_status | (low_cnt >= RESTORE_CYC));
        // request ends with power and is left low, never floating high
        link_request_line <= want_req & want_power;
    end
endmodule : link_ctrl_model

// File: tb/tb.sv
// bench for the link interface reset, disable and init sequencer
`timescale 1ns/1ps
module tb
    import link_iface_pkg::*;
;
    localparam int WAKE_SIM = 20;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic want_power = 1'b0;
    logic want_req = 1'b0;
    logic isolated_mode_n = 1'b1;
    logic ports_active = 1'b0;
    logic request_served = 1'b0;
    logic status_event = 1'b0;
    logic status_taken = 1'b0;
    logic link_power_status;
    logic link_request_line;
    logic link_side_clock;
    logic link_side_clock_oe;
    logic [CTL_W-1:0] control_lines;
    logic [DATA_W-1:0] data_lines;
    logic link_lines_oe;
    logic low_power;
    logic interface_ready;
    logic request_pending;
    logic status_pending;
    wire [9:0] lines = {control_lines, data_lines};
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #12.5 clk_sys = ~clk_sys;

    link_ctrl_model ctrl (.clk_sys(clk_sys), .want_power(want_power), .want_req(want_req),
        .link_power_status(link_power_status), .link_request_line(link_request_line));

    phy_link_iface_reset_disable_init #(.WAKE_CYCLES(WAKE_SIM)) dut (.clk_sys(clk_sys),
        .rst_n(rst_n), .link_power_status(link_power_status),
        .isolated_mode_n(isolated_mode_n), .ports_active(ports_active),
        .link_request_line(link_request_line), .request_served(request_served),
        .status_event(status_event), .status_taken(status_taken),
        .link_side_clock(link_side_clock), .link_side_clock_oe(link_side_clock_oe),
        .control_lines(control_lines), .data_lines(data_lines), .link_lines_oe(link_lines_oe),
        .low_power(low_power), .interface_ready(interface_ready),
        .request_pending(request_pending), .status_pending(status_pending));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    // whole run needs about 4000 cycles
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            fails++;
            $display("BAD %0t timeout", $time);
            report_and_stop();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask : tick

    task automatic check(input logic [9:0] got, input logic [9:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t %s", $time, what);
        end
    endtask : check

    task automatic set_power(input logic v);
        int n;
        n = 0;
        want_power = v;
        while (link_power_status !== v && n < 2000)
        begin
            tick(1);
            n++;
        end
        check(10'(link_power_status), 10'(v), "power pin");
    endtask : set_power

    task automatic t_disabled(input logic iso_n);
        int k;
        logic first;
        tick(30);
        status_event = 1'b1;
        tick(1);
        status_event = 1'b0;
        first = link_side_clock;
        for (k = 0; k < 8; k++)
        begin
            check(10'(link_side_clock), 10'(first), "clock stopped");
            tick(1);
        end
        if (iso_n)
            check(10'(link_side_clock), 10'h000, "clock held low");
        check(10'(link_side_clock_oe), 10'(iso_n), "clock pin drive");
        check(lines, 10'h000, "lines at zero");
        check(10'(link_lines_oe), 10'(iso_n), "lines drive");
        check(10'(interface_ready), 10'h000, "not ready");
        check(10'(status_pending), 10'h000, "status ignored");
        check(10'(low_power), 10'(!ports_active), "low power");
        $display("test disabled state done");
    endtask : t_disabled

    task automatic t_init(input logic iso_n, input int lo, input int hi);
        int n;
        int k;
        int h;
        int j;
        logic drive;
        logic pre_oe;
        logic [9:0] exp;
        set_power(1'b1);
        n = 0;
        pre_oe = 1'b0;
        while (link_side_clock !== 1'b1 && n < hi + 5)
        begin
            pre_oe = link_side_clock_oe;
            tick(1);
            n++;
        end
        check(10'(n >= lo && n <= hi), 10'h001, "restart time");
        check(10'(pre_oe), 10'h001, "low half cycle driven");
        for (k = 1; k <= 9; k++)
        begin
            // in isolated mode the controller holds request up early; the device must not take it
            want_req = ~iso_n & (k < 5);
            for (h = 0; h < 2; h++)
            begin
                // lines move on the falling half, half a link cycle after each rise
                j = k - 1 + h;
                if (j < 8)
                    exp = 10'h000;
                else if (j == 8)
                    exp = {CTL_RECEIVE, DATA_ONES};
                else
                    exp = {CTL_IDLE, DATA_ZERO};
                drive = iso_n | (j == 1) | (j >= 8);
                check(10'(link_side_clock), 10'(h == 0), "clock square wave");
                check(lines, exp, "init lines");
                check(10'(link_lines_oe), 10'(drive), "init drive");
                tick(1);
            end
        end
        check(10'(interface_ready), 10'h001, "ready after init");
        check(10'(request_pending), 10'h000, "early request ignored");
        $display("test init done");
    endtask : t_init

    task automatic t_requests();
        want_req = 1'b1;
        tick(1);
        want_req = 1'b0;
        tick(4);
        check(10'(request_pending), 10'h001, "request taken");
        request_served = 1'b1;
        tick(1);
        request_served = 1'b0;
        check(10'(request_pending), 10'h000, "request served");
        status_event = 1'b1;
        tick(1);
        check(10'(status_pending), 10'h001, "status queued");
        status_taken = 1'b1;
        tick(1);
        status_event = 1'b0;
        check(10'(status_pending), 10'h001, "new status wins over clear");
        tick(1);
        status_taken = 1'b0;
        check(10'(status_pending), 10'h000, "status taken");
        status_event = 1'b1;
        tick(1);
        status_event = 1'b0;
        check(10'(status_pending), 10'h001, "status queued again");
        $display("test requests done");
    endtask : t_requests

    task automatic t_reset_only();
        int n;
        logic first;
        set_power(1'b0);
        tick(103);
        check(10'(interface_ready), 10'h001, "reset too early");
        tick(5);
        check(10'(interface_ready), 10'h000, "reset entered");
        check(10'(status_pending), 10'h000, "status dropped");
        check(lines, 10'h000, "lines low");
        check(10'(link_lines_oe), 10'h001, "lines driven");
        first = link_side_clock;
        tick(1);
        check(10'(link_side_clock), 10'(!first), "clock still runs");
        // well short of the disable time, past the restore interval
        tick(600);
        set_power(1'b1);
        n = 0;
        while (control_lines !== CTL_RECEIVE && n < 40)
        begin
            tick(1);
            n++;
        end
        check(lines, {CTL_RECEIVE, DATA_ONES}, "receive after reset");
        tick(2);
        check(lines, {CTL_IDLE, DATA_ZERO}, "idle after reset");
        check(10'(interface_ready), 10'h001, "ready after reset");
        $display("test reset only done");
    endtask : t_reset_only

    task automatic t_disable(input logic iso_n);
        logic first;
        set_power(1'b0);
        tick(1035);
        first = link_side_clock;
        tick(1);
        check(10'(link_side_clock), 10'(!first), "disabled too early");
        tick(15);
        t_disabled(iso_n);
    endtask : t_disable

    initial
    begin
        tick(16);
        rst_n = 1'b1;
        t_disabled(1'b1);
        t_init(1'b1, WAKE_SIM, WAKE_SIM + 10);
        t_requests();
        t_reset_only();
        ports_active = 1'b1;
        t_disable(1'b1);
        isolated_mode_n = 1'b0;
        tick(5);
        t_init(1'b0, 1, 8);
        ports_active = 1'b0;
        t_disable(1'b0);
        report_and_stop();
    end
endmodule : tb
